// ### common/lhp_regs.vh
`ifndef LHP_REGS_VH
`define LHP_REGS_VH
`define LHP_FIFO_WIDTH 9
`define LHP_FIFO_DEPTH 8
`define LHP_SER_BITS 4'h8
`define LHP_BOOST_MIN 3'h2
`define LHP_BOOST_MAX 3'h6
`define LHP_BOOST_RESET 3'h6
`define LHP_OP_BOOST 5'h15
`define LHP_STATUS_BUSY_BIT 7
`endif

// ### design/lhp_fifo.v
`timescale 1ns/10ps
`default_nettype none
module lhp_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clock,
  input wire rst_b,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [AW:0] FULL = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  assign in_ready = (count != FULL);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// ### design/lhp_host_port.v
`timescale 1ns/10ps
`default_nettype none
`include "lhp_regs.vh"
// Function
// - Select high: eight data pins form a two-way parallel bus.
// - Select low: top pin is serial data, next pin serial clock, inputs only.
// - Serial mode floats the six lowest data pins always.
// - Chip select high floats all data pins and ignores bus activity.
// - Discriminator high carries display data, low carries an instruction.
// - Reset stays in progress while reset_n is held low.
// - An instruction sets booster factor from two to six.
// - Power straps gate booster and regulator availability; follower is always enabled.
// - 80 type: drive on read strobe low, capture write on strobe rise.
// - 68 type: enable high strobe, direction high read, low write.
// - Bus type strap high selects 68 type, low selects 80 type.
// - Serial mode gives no reads; host holds strobes fixed.
module lhp_host_port (
  // Clock and reset
  input wire clock,
  input wire rst_b,
  // Host pins
  input wire reset_n,
  input wire interface_select,
  input wire bus_type_strap,
  input wire chip_select_n,
  input wire data_instruction_select,
  input wire read_strobe,
  input wire write_strobe,
  input wire [7:0] bus_in,
  output reg [7:0] bus_out,
  output reg [7:0] bus_oe_n,
  // Power straps
  input wire power_strap_a,
  input wire power_strap_b,
  // Transfer stream to the core
  output reg xfer_valid,
  input wire xfer_ready,
  output reg [7:0] xfer_data,
  output reg xfer_is_data,
  // Read data from the core
  input wire [7:0] read_data,
  input wire read_is_status,
  output reg read_taken,
  // Status and power control
  output reg core_reset,
  output reg [2:0] boost_factor,
  output reg booster_enable,
  output reg regulator_enable,
  output reg follower_enable,
  output reg overflow
);
  reg strobe_q;
  reg sclk_q;
  reg [7:0] shift;
  reg [3:0] bit_cnt;
  reg [2:0] boost_req;
  reg f_valid;
  reg [8:0] f_data;
  reg read_active_q;
  wire f_ready;
  wire f_out_valid;
  wire [8:0] f_out_data;
  wire selected;
  wire mode68;
  wire rd_act;
  wire wr_act;
  wire wr_done;
  wire sclk_rise;
  wire [7:0] next_shift;
  function bus_read_active;
    input is68;
    input rd;
    input wr;
    begin
      bus_read_active = is68 ? (rd && wr) : !rd;
    end
  endfunction
  assign selected = !chip_select_n && reset_n;
  assign mode68 = bus_type_strap;
  assign rd_act = selected && interface_select && bus_read_active(mode68, read_strobe, write_strobe);
  assign wr_act = mode68 ? (read_strobe && !write_strobe) : !write_strobe;
  assign wr_done = selected && interface_select && strobe_q && !wr_act;
  assign sclk_rise = selected && !interface_select && bus_in[6] && !sclk_q;
  assign next_shift = {shift[6:0], bus_in[7]};
  lhp_fifo #(
    .WIDTH(`LHP_FIFO_WIDTH),
    .DEPTH(`LHP_FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clock(clock),
    .rst_b(rst_b),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .in_data(f_data),
    .out_valid(f_out_valid),
    .out_ready(!xfer_valid || xfer_ready),
    .out_data(f_out_data)
  );
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      strobe_q <= 1'b0;
      sclk_q <= 1'b0;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      f_valid <= 1'b0;
      f_data <= 9'h000;
      overflow <= 1'b0;
      core_reset <= 1'b1;
      read_active_q <= 1'b0;
      read_taken <= 1'b0;
    end else begin
      core_reset <= !reset_n;
      read_active_q <= rd_act;
      read_taken <= rd_act && !read_active_q && !read_is_status;
      f_valid <= 1'b0;
      if (!reset_n) begin
        strobe_q <= 1'b0;
        sclk_q <= 1'b0;
        shift <= 8'h00;
        bit_cnt <= 4'h0;
        overflow <= 1'b0;
      end else begin
        strobe_q <= selected && interface_select && wr_act;
        sclk_q <= bus_in[6];
        if (!selected || interface_select) begin
          bit_cnt <= 4'h0;
        end
        if (wr_done) begin
          f_valid <= 1'b1;
          f_data <= {data_instruction_select, bus_in};
          overflow <= overflow || !f_ready;
        end
        if (sclk_rise) begin
          shift <= next_shift;
          if (bit_cnt == `LHP_SER_BITS - 4'h1) begin
            bit_cnt <= 4'h0;
            f_valid <= 1'b1;
            f_data <= {data_instruction_select, next_shift};
            overflow <= overflow || !f_ready;
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
      end
    end
  end
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      xfer_valid <= 1'b0;
      xfer_data <= 8'h00;
      xfer_is_data <= 1'b0;
      boost_req <= `LHP_BOOST_RESET;
    end else if (!reset_n) begin
      xfer_valid <= 1'b0;
      boost_req <= `LHP_BOOST_RESET;
    end else begin
      if (xfer_valid && xfer_ready) begin
        xfer_valid <= 1'b0;
      end
      if (f_out_valid && (!xfer_valid || xfer_ready)) begin
        xfer_valid <= 1'b1;
        xfer_data <= f_out_data[7:0];
        xfer_is_data <= f_out_data[8];
        if (!f_out_data[8] && f_out_data[7:3] == `LHP_OP_BOOST) begin
          if (f_out_data[2:0] >= `LHP_BOOST_MIN && f_out_data[2:0] <= `LHP_BOOST_MAX) begin
            boost_req <= f_out_data[2:0];
          end
        end
      end
    end
  end
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus_out <= 8'h00;
      bus_oe_n <= 8'hff;
      boost_factor <= `LHP_BOOST_RESET;
      booster_enable <= 1'b0;
      regulator_enable <= 1'b0;
      follower_enable <= 1'b0;
    end else begin
      bus_out <= read_data;
      bus_oe_n <= rd_act ? 8'h00 : 8'hff;
      boost_factor <= boost_req;
      booster_enable <= !power_strap_a;
      regulator_enable <= !power_strap_a || !power_strap_b;
      follower_enable <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### verif/lhp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module lhp_host_model (
  input wire logic clock,
  output logic chip_select_n = 1'b1,
  output logic data_instruction_select = 1'b0,
  output logic read_strobe = 1'b1,
  output logic write_strobe = 1'b1,
  output logic [7:0] bus_in = 8'h00
);
  task automatic wr(input logic is68, di, input logic [7:0] d);
    @(posedge clock);
    chip_select_n <= 1'b0;
    data_instruction_select <= di;
    bus_in <= d;
    read_strobe <= 1'b1;
    write_strobe <= 1'b0;
    repeat (2) @(posedge clock);
    read_strobe <= !is68;
    write_strobe <= 1'b1;
    @(posedge clock);
    chip_select_n <= 1'b1;
    bus_in <= ~d;
    @(posedge clock);
  endtask
  task automatic rd(input logic is68);
    @(posedge clock);
    chip_select_n <= 1'b0;
    read_strobe <= is68;
    repeat (3) @(posedge clock);
    chip_select_n <= 1'b1;
    read_strobe <= !is68;
  endtask
  // Serial clock stands low between frames, strobes stay fixed
  task automatic ser(input logic di, input logic [7:0] d);
    int i;
    @(posedge clock);
    chip_select_n <= 1'b0;
    data_instruction_select <= di;
    for (i = 7; i >= 0; i--) begin
      bus_in <= {d[i], 7'h00};
      @(posedge clock);
      bus_in[6] <= 1'b1;
      @(posedge clock);
    end
    bus_in <= {~d[0], 7'h00};
    chip_select_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### verif/lhp_host_port_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module lhp_chk (
  // Clock, reset and host pins
  input wire logic clock, rst_b, reset_n, interface_select, bus_type_strap,
  input wire logic chip_select_n, read_strobe, write_strobe, power_strap_a, power_strap_b,
  // Core side
  input wire logic xfer_valid, xfer_ready, xfer_is_data, core_reset,
  input wire logic booster_enable, regulator_enable,
  input wire logic [7:0] bus_oe_n, xfer_data,
  input wire logic [2:0] boost_factor
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire logic rd_ok = interface_select && !chip_select_n && reset_n;
  cs_float_a: assert property ($past(chip_select_n) |-> &bus_oe_n)
    else $error("pins driven while deselected");
  ser_low_a: assert property ($past(!interface_select) |-> &bus_oe_n[5:0])
    else $error("low pins driven in serial mode");
  ser_top_a: assert property ($past(!interface_select) |-> &bus_oe_n[7:6])
    else $error("serial inputs driven");
  rd80_a: assert property (
    $past(rd_ok && !bus_type_strap && !read_strobe) |-> bus_oe_n == 8'h00)
    else $error("80 type read not driven");
  rd68_a: assert property (
    $past(rd_ok && bus_type_strap && read_strobe && write_strobe) |-> bus_oe_n == 8'h00)
    else $error("68 type read not driven");
  hold_a: assert property (xfer_valid && !xfer_ready && reset_n |=>
    xfer_valid && $stable(xfer_data) && $stable(xfer_is_data)) else $error("transfer lost");
  core_rst_a: assert property (!reset_n |=> core_reset)
    else $error("reset not held");
  boost_a: assert property (boost_factor >= 3'h2 && boost_factor <= 3'h6)
    else $error("booster factor out of range");
  power_a: assert property ($past(power_strap_a) |->
    !booster_enable && !(regulator_enable && $past(power_strap_b))) else $error("strap gating");
endmodule
bind lhp_host_port lhp_chk u_lhp_chk (.*);
`default_nettype wire

// ### verif/tb_lhp_host_port.sv
`timescale 1ns/10ps
`default_nettype none
module tb_lhp_host_port;
  logic clock = 1'b0, rst_b = 1'b0, reset_n = 1'b1, interface_select = 1'b1;
  logic bus_type_strap = 1'b0, power_strap_a = 1'b0, power_strap_b = 1'b0;
  logic xfer_ready = 1'b1, read_is_status = 1'b0;
  logic [7:0] read_data = 8'h5a;
  wire logic chip_select_n, data_instruction_select, read_strobe, write_strobe;
  wire logic xfer_valid, xfer_is_data, read_taken, core_reset, overflow;
  wire logic booster_enable, regulator_enable, follower_enable;
  wire logic [7:0] bus_in, bus_out, bus_oe_n, xfer_data;
  wire logic [2:0] boost_factor;
  int err_count = 0, checked = 0, cycles = 0, i;
  logic seen_rd = 1'b0;
  always @(posedge clock) if (read_taken === 1'b1) seen_rd <= 1'b1;
  always #5 clock = ~clock;
  lhp_host_model u_lhp_host_model (.*);
  lhp_host_port u_lhp_host_port (.*);
  task automatic chk(input logic [9:0] got, exp);
    #1 checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic get(input logic di, input logic [7:0] d);
    int n = 0;
    while (n < 20 && xfer_valid !== 1'b1) begin
      @(posedge clock);
      #1 n++;
    end
    chk({xfer_valid, xfer_is_data, xfer_data}, {1'b1, di, d});
    @(posedge clock);
    #1;
  endtask
  task automatic end_of_test;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock) if (++cycles == 20000) begin
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    u_lhp_host_model.wr(0, 1, 8'ha5);
    get(1, 8'ha5);
    u_lhp_host_model.wr(0, 0, 8'h3c);
    get(0, 8'h3c);
    u_lhp_host_model.rd(0);
    chk({bus_oe_n == 8'h00, seen_rd, bus_out}, {2'b11, 8'h5a});
    xfer_ready <= 1'b0;
    for (i = 0; i < 10; i++) u_lhp_host_model.wr(0, 1, 8'h10 + i[7:0]);
    chk(overflow, 1'b1);
    xfer_ready <= 1'b1;
    for (i = 0; i < 8; i++) get(1, 8'h10 + i[7:0]);
    for (i = 7; i >= 1; i--) begin
      u_lhp_host_model.wr(0, 0, {5'h15, i[2:0]});
      repeat (8) @(posedge clock);
      chk(boost_factor, (i > 6) ? 3'h6 : (i < 2) ? 3'h2 : i[2:0]);
    end
    for (i = 0; i < 4; i++) begin
      @(posedge clock);
      {power_strap_a, power_strap_b} <= i[1:0];
      repeat (3) @(posedge clock);
      chk({booster_enable, regulator_enable, follower_enable}, {~i[1], ~&i[1:0], 1'b1});
    end
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    chk({core_reset, boost_factor}, 4'he);
    @(posedge clock);
    reset_n <= 1'b1;
    bus_type_strap <= 1'b1;
    u_lhp_host_model.wr(1, 1, 8'h96);
    get(1, 8'h96);
    u_lhp_host_model.rd(1);
    chk({bus_oe_n == 8'h00, bus_out}, {1'b1, 8'h5a});
    @(posedge clock);
    bus_type_strap <= 1'b0;
    interface_select <= 1'b0;
    u_lhp_host_model.ser(1, 8'hc3);
    get(1, 8'hc3);
    chk(bus_oe_n, 8'hff);
    end_of_test();
  end
endmodule
`default_nettype wire
